//--- cac_cc_if.sv
// carrier between the control registers and the module 2 unit
// assumes both ends run on ref_clk
`timescale 1ns/1ps
interface cac_cc_if;
  logic [15:0] count;
  logic        step;
  logic [15:0] cmp;
  logic [7:0]  mode;
  logic        cap_ev;
  logic        hit_ev;
  logic        pin;
  modport ctl  (output count, step, cmp, mode, input cap_ev, hit_ev, pin);
  modport unit (input count, step, cmp, mode, output cap_ev, hit_ev, pin);
endinterface

//--- cac_pkg.sv
// constants shared by the counter array control block and its module 2 unit
// assumes a byte-wide special function register port on one clock
package cac_pkg;
  // register addresses
  localparam logic [7:0] CTRL_ADDR  = 8'hD8;
  localparam logic [7:0] MODE2_ADDR = 8'hDC;
  localparam logic [7:0] CMPL2_ADDR = 8'hEB;
  localparam logic [7:0] CMPH2_ADDR = 8'hEC;
  // array_control fields
  localparam int OVF_BIT = 7;
  localparam int RUN_BIT = 6;
  localparam int F2_BIT  = 2;
  localparam int F1_BIT  = 1;
  localparam int F0_BIT  = 0;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hC7;
  // module2_mode fields
  localparam int WIDE_BIT = 7;
  localparam int COMPARATOR_ENABLE_BIT = 6;
  localparam int RISE_BIT = 5;
  localparam int FALL_BIT = 4;
  localparam int HIT_BIT  = 3;
  localparam int FLIP_BIT = 2;
  localparam int PWM_BIT  = 1;
  localparam int MASK_BIT = 0;
  localparam logic [7:0] MODE_RST = 8'h00;
  // counter values
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE  = 16'h0001;
  localparam logic [15:0] CMP_RST  = 16'h0000;
  localparam logic [7:0]  LOW_ZERO = 8'h00;
  localparam logic [7:0]  RD_ZERO  = 8'h00;
  typedef enum {OM_IDLE, OM_TOG, OM_FREQ, OM_PWM8, OM_WIDE_PULSE_MODE} cac_omode_t;
endpackage

//--- cac_top.sv
// counter array control: run control, overflow and event flags,
// module 2 mode register, compare value and interrupt request
// assumes a byte special function register port on ref_clk, and
// interrupt enables of overflow, module 0 and 1 kept elsewhere
// Functional notes
// RULE1: overflow flag set when the counter wraps from all ones to zero.
// RULE2: overflow flag with its enable raises the array interrupt request.
// RULE3: all flags stay set until software writes them to zero.
// RULE4: run control bit 6 stops the counter at 0, runs it at 1.
// RULE5: software writes reserved control bits 5..3 with their reset value.
// RULE6: event flags bits 2..0 set by hardware on match or capture.
// RULE7: an enabled module event flag raises the array interrupt request.
// RULE8: wide pulse bit 7 picks 16-bit pwm, else 8-bit pwm.
// RULE9: comparator enable bit 6 turns on counter to compare matching.
// RULE10: rising capture bit 5 arms capture on input rising edge.
// RULE11: falling capture bit 4 arms capture on input falling edge.
// RULE12: hit enable bit 3 makes each match set the module 2 flag.
// RULE13: flip bit 2 makes each match invert the module 2 output.
// RULE14: flip and pwm together select frequency output mode.
// RULE15: pwm bit 1 drives a pulse-width waveform on the output.
// RULE16: mask bit 0 gates module 2 event interrupts.
// RULE17: low compare write clears comparator enable, high write sets it.
// RULE18: in pwm with hit enable, flag sets on match and up edges.
// RULE19: running counter advances by one per tick, else holds.
`timescale 1ns/1ps
module cac_top (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_rd,
  output logic      [7:0]  sfr_rdata,
  input  wire logic        count_tick,
  input  wire logic        module2_input_pin,
  input  wire logic        module0_event,
  input  wire logic        module1_event,
  input  wire logic        overflow_irq_enable,
  input  wire logic        module0_irq_enable,
  input  wire logic        module1_irq_enable,
  output logic             array_irq,
  output logic             module2_output_pin,
  output logic      [15:0] array_count
);
  logic [7:0]  ctrl_q, ctrl_d;
  logic [7:0]  mode_q, mode_d;
  logic [15:0] cmp_q, cmp_d;
  logic [15:0] cnt_q, cnt_d;
  logic        step_q, step_d;
  logic        irq_q, irq_d;
  logic [7:0]  rd_q, rd_d;
  logic        wr_ctrl, wr_mode, wr_cl, wr_ch, adv, wrap;
  logic [7:0]  hw_set;

  cac_cc_if cc ();

  //////////////////////////////////////////////////////////////////////////
  // module 2 unit

  assign cc.count = cnt_q;
  assign cc.step  = step_q;
  assign cc.cmp   = cmp_q;
  assign cc.mode  = mode_q;

  cac_unit cac_unit_inst (
    .ref_clk (ref_clk),
    .reset   (reset),
    .in_pin  (module2_input_pin),
    .u       (cc.unit)
  );

  //////////////////////////////////////////////////////////////////////////
  // register write decode

  always_comb
  begin
    wr_ctrl = sfr_wr & (sfr_addr == cac_pkg::CTRL_ADDR);
    wr_mode = sfr_wr & (sfr_addr == cac_pkg::MODE2_ADDR);
    wr_cl   = sfr_wr & (sfr_addr == cac_pkg::CMPL2_ADDR);
    wr_ch   = sfr_wr & (sfr_addr == cac_pkg::CMPH2_ADDR);
  end

  //////////////////////////////////////////////////////////////////////////
  // array counter

  always_comb
  begin
    adv    = ctrl_q[cac_pkg::RUN_BIT] & count_tick; // [RULE4]
    wrap   = adv & (cnt_q == cac_pkg::CNT_MAX);      // [RULE1]
    cnt_d  = adv ? cnt_q + cac_pkg::CNT_ONE : cnt_q; // [RULE19]
    step_d = adv;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cnt_q  <= cac_pkg::CNT_ZERO;
      step_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      step_q <= step_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control register: a hardware set in the cycle of a software clear wins

  always_comb
  begin
    hw_set                  = 8'h00;
    hw_set[cac_pkg::OVF_BIT] = wrap;                        // [RULE1]
    hw_set[cac_pkg::F2_BIT]  = cc.cap_ev | cc.hit_ev;       // [RULE6]
    hw_set[cac_pkg::F1_BIT]  = module1_event;               // [RULE6]
    hw_set[cac_pkg::F0_BIT]  = module0_event;               // [RULE6]
    ctrl_d = ctrl_q;
    // reserved bits never store, so they read back as zero
    if (wr_ctrl)
      ctrl_d = sfr_wdata & cac_pkg::CTRL_WMASK;             // [RULE5]
    ctrl_d = ctrl_d | hw_set;                               // [RULE3]
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      ctrl_q <= cac_pkg::CTRL_RST;
    else
      ctrl_q <= ctrl_d;
  end

  //////////////////////////////////////////////////////////////////////////
  // mode register and compare value

  always_comb
  begin
    mode_d = mode_q;
    cmp_d  = cmp_q;
    if (wr_mode)
      mode_d = sfr_wdata;
    // low byte first: writing it disarms the match until the high byte
    if (wr_cl)
    begin
      cmp_d[7:0]                = sfr_wdata;
      mode_d[cac_pkg::COMPARATOR_ENABLE_BIT] = 1'b0;                     // [RULE17]
    end
    if (wr_ch)
    begin
      cmp_d[15:8]               = sfr_wdata;
      mode_d[cac_pkg::COMPARATOR_ENABLE_BIT] = 1'b1;                     // [RULE17]
    end
    // capture outranks a software write of the same cycle
    if (cc.cap_ev)
      cmp_d = cnt_q;                                        // [RULE10]
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      mode_q <= cac_pkg::MODE_RST;
      cmp_q  <= cac_pkg::CMP_RST;
    end
    else
    begin
      mode_q <= mode_d;
      cmp_q  <= cmp_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt request and read data

  always_comb
  begin
    irq_d = (ctrl_q[cac_pkg::OVF_BIT] & overflow_irq_enable)      // [RULE2]
          | (ctrl_q[cac_pkg::F2_BIT] & mode_q[cac_pkg::MASK_BIT]) // [RULE16]
          | (ctrl_q[cac_pkg::F1_BIT] & module1_irq_enable)        // [RULE7]
          | (ctrl_q[cac_pkg::F0_BIT] & module0_irq_enable);       // [RULE7]
    rd_d = rd_q;
    if (sfr_rd)
    begin
      unique case (sfr_addr)
        cac_pkg::CTRL_ADDR:  rd_d = ctrl_q;
        cac_pkg::MODE2_ADDR: rd_d = mode_q;
        cac_pkg::CMPL2_ADDR: rd_d = cmp_q[7:0];
        cac_pkg::CMPH2_ADDR: rd_d = cmp_q[15:8];
        default:             rd_d = cac_pkg::RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      irq_q <= 1'b0;
      rd_q  <= cac_pkg::RD_ZERO;
    end
    else
    begin
      irq_q <= irq_d;
      rd_q  <= rd_d;
    end
  end

  assign sfr_rdata          = rd_q;
  assign array_irq          = irq_q;
  assign module2_output_pin = cc.pin;
  assign array_count        = cnt_q;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  overflow_sets_a: assert property ( // [RULE1]
    (cnt_q == cac_pkg::CNT_MAX) && adv |=> ctrl_q[cac_pkg::OVF_BIT]
      && cnt_q == cac_pkg::CNT_ZERO)
    else $error("overflow flag not set on wrap");

  overflow_irq_a: assert property ( // [RULE2]
    ctrl_q[cac_pkg::OVF_BIT] && overflow_irq_enable |=> array_irq)
    else $error("overflow did not request interrupt");

  flags_sticky_a: assert property ( // [RULE3]
    $fell(ctrl_q[cac_pkg::F2_BIT]) || $fell(ctrl_q[cac_pkg::OVF_BIT])
      |-> $past(wr_ctrl))
    else $error("flag cleared without software write");

  run_holds_a: assert property ( // [RULE4]
    !ctrl_q[cac_pkg::RUN_BIT] |=> $stable(cnt_q))
    else $error("counter moved while stopped");

  reserved_zero_a: assert property ( // [RULE5]
    ctrl_q[5:3] == 3'h0)
    else $error("reserved control bits not zero");

  count_step_a: assert property ( // [RULE19]
    adv |=> cnt_q == $past(cnt_q) + cac_pkg::CNT_ONE)
    else $error("counter did not advance by one");

  hit_flag_a: assert property ( // [RULE12]
    mode_q[cac_pkg::HIT_BIT] && mode_q[cac_pkg::COMPARATOR_ENABLE_BIT]
      && !mode_q[cac_pkg::PWM_BIT] && step_q && cnt_q == cmp_q
      && !wr_mode && !wr_cl |-> ##2 ctrl_q[cac_pkg::F2_BIT])
    else $error("match did not set module 2 flag");

  toggle_pin_a: assert property ( // [RULE13]
    mode_q[cac_pkg::FLIP_BIT] && !mode_q[cac_pkg::PWM_BIT]
      && mode_q[cac_pkg::COMPARATOR_ENABLE_BIT] && step_q && cnt_q == cmp_q
      |=> module2_output_pin != $past(module2_output_pin))
    else $error("toggle mode pin did not invert");

  mask_irq_a: assert property ( // [RULE16]
    ctrl_q[cac_pkg::F2_BIT] && mode_q[cac_pkg::MASK_BIT] |=> array_irq)
    else $error("module 2 event did not request interrupt");

  comp_write_a: assert property ( // [RULE17]
    wr_cl && !wr_mode |=> !mode_q[cac_pkg::COMPARATOR_ENABLE_BIT])
    else $error("low compare write left comparator on");

  ev_irq_a: assert property ( // [RULE7]
    ctrl_q[cac_pkg::F0_BIT] && module0_irq_enable |=> array_irq)
    else $error("module 0 event did not request interrupt");

  wide_match_a: assert property ( // [RULE8]
    mode_q[cac_pkg::PWM_BIT] && mode_q[cac_pkg::WIDE_BIT]
      && !mode_q[cac_pkg::FLIP_BIT] && mode_q[cac_pkg::COMPARATOR_ENABLE_BIT]
      && step_q && cnt_q == cmp_q |=> !module2_output_pin)
    else $error("wide pwm match did not drive low");

  pwm_rise_a: assert property ( // [RULE15]
    mode_q[cac_pkg::PWM_BIT] && !mode_q[cac_pkg::WIDE_BIT]
      && !mode_q[cac_pkg::FLIP_BIT] && step_q
      && cnt_q[7:0] == cac_pkg::LOW_ZERO
      && cmp_q[7:0] != cac_pkg::LOW_ZERO |=> module2_output_pin)
    else $error("pwm up edge did not drive high");

  freq_flip_a: assert property ( // [RULE14]
    mode_q[cac_pkg::PWM_BIT] && mode_q[cac_pkg::FLIP_BIT]
      && mode_q[cac_pkg::COMPARATOR_ENABLE_BIT] && step_q
      && cnt_q[7:0] == cmp_q[7:0]
      |=> module2_output_pin != $past(module2_output_pin))
    else $error("frequency mode pin did not invert");

  capture_load_a: assert property ( // [RULE10]
    cc.cap_ev |=> cmp_q == $past(cnt_q))
    else $error("capture did not load counter value");

  module_flag_a: assert property ( // [RULE6]
    module1_event |=> ctrl_q[cac_pkg::F1_BIT])
    else $error("module 1 event did not set its flag");

  comp_high_a: assert property ( // [RULE17]
    wr_ch |=> mode_q[cac_pkg::COMPARATOR_ENABLE_BIT])
    else $error("high compare write left comparator off");

  up_flag_a: assert property ( // [RULE18]
    mode_q[cac_pkg::HIT_BIT] && mode_q[cac_pkg::PWM_BIT]
      && mode_q[cac_pkg::WIDE_BIT] && !mode_q[cac_pkg::FLIP_BIT]
      && step_q && cnt_q == cac_pkg::CNT_ZERO
      |-> ##2 ctrl_q[cac_pkg::F2_BIT])
    else $error("pwm up edge did not set module 2 flag");

  // request follows the flag by one more register stage
  wrap_seen_c: cover property (wrap ##2 array_irq);
  capture_seen_c: cover property (cc.cap_ev ##2 ctrl_q[cac_pkg::F2_BIT]);
  pwm_seen_c: cover property (mode_q[cac_pkg::PWM_BIT]
    && $rose(module2_output_pin));
  clear_seen_c: cover property (wr_ctrl && hw_set != 8'h00);
endmodule // cac_top

//--- cac_top_tb.sv
// register-level bench for the counter array control block
// assumes cac_top with its package; single ref_clk domain
`timescale 1ns/1ps
module cac_top_tb;
  logic        ref_clk, reset, sfr_wr, sfr_rd, count_tick;
  logic        module2_input_pin, module0_event, module1_event;
  logic        overflow_irq_enable, module0_irq_enable, module1_irq_enable;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
  logic        array_irq, module2_output_pin;
  logic [15:0] array_count, exp_cnt;
  int          failures, check_count, n;

  cac_top cac_top_inst (
    .ref_clk(ref_clk), .reset(reset), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .count_tick(count_tick),
    .module2_input_pin(module2_input_pin),
    .module0_event(module0_event), .module1_event(module1_event),
    .overflow_irq_enable(overflow_irq_enable),
    .module0_irq_enable(module0_irq_enable),
    .module1_irq_enable(module1_irq_enable), .array_irq(array_irq),
    .module2_output_pin(module2_output_pin), .array_count(array_count)
  );

  initial
  begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("mismatches %0d of %0d checks", failures, check_count);
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk_val(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask

  // every bus task enters and leaves on a falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'h1;
    @(negedge ref_clk);
    sfr_wr = 1'h0;
    @(negedge ref_clk);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1'h1;
    @(negedge ref_clk);
    sfr_rd = 1'h0;
    @(negedge ref_clk);
    chk_val(nm, {8'h00, e}, {8'h00, sfr_rdata});
  endtask

  // single spaced ticks, then time for the module 2 pipeline to settle
  task automatic ticks(input int k, input logic adv);
    repeat (k)
    begin
      count_tick = 1'h1;
      @(negedge ref_clk);
      count_tick = 1'h0;
      @(negedge ref_clk);
    end
    if (adv)
      exp_cnt = exp_cnt + k[15:0];
    repeat (4) @(negedge ref_clk);
    chk_val("array_count", exp_cnt, array_count);
  endtask

  // synchroniser plus capture pipeline needs several cycles
  task automatic cap(input logic lvl, input logic f, input logic irq);
    module2_input_pin = lvl;
    repeat (8) @(negedge ref_clk);
    rd_chk("ctrl after edge", cac_pkg::CTRL_ADDR, {5'h08, f, 2'h0});
    chk_bit("array_irq", irq, array_irq);
    wr(cac_pkg::CTRL_ADDR, 8'h40);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    failures++;
    $display("[ERR] run time limit expected end seen none");
    conclude();
  end

  initial
  begin
    {reset, sfr_wr, sfr_rd, count_tick, module2_input_pin} = 5'h10;
    {module0_event, module1_event, overflow_irq_enable} = 3'h0;
    {module0_irq_enable, module1_irq_enable} = 2'h0;
    {sfr_addr, sfr_wdata} = 16'h0000;
    exp_cnt = 16'h0000;
    failures = 0;
    check_count = 0;
    repeat (5) @(negedge ref_clk);
    reset = 1'h0;
    rd_chk("ctrl reset", cac_pkg::CTRL_ADDR, cac_pkg::CTRL_RST);
    rd_chk("mode reset", cac_pkg::MODE2_ADDR, cac_pkg::MODE_RST);
    rd_chk("unmapped", 8'h00, 8'h00);
    wr(cac_pkg::CTRL_ADDR, 8'h00);
    rd_chk("reserved bits", cac_pkg::CTRL_ADDR, 8'h00);
    ticks(3, 1'h0);
    wr(cac_pkg::CTRL_ADDR, 8'h40);
    ticks(5, 1'h1);
    // module 0 and 1 flags, one interrupt enabled
    module1_irq_enable = 1'h1;
    module0_event = 1'h1;
    @(negedge ref_clk);
    module0_event = 1'h0;
    repeat (3) @(negedge ref_clk);
    rd_chk("flag0", cac_pkg::CTRL_ADDR, 8'h41);
    chk_bit("irq masked", 1'h0, array_irq);
    module1_event = 1'h1;
    @(negedge ref_clk);
    module1_event = 1'h0;
    repeat (3) @(negedge ref_clk);
    rd_chk("flag1", cac_pkg::CTRL_ADDR, 8'h43);
    chk_bit("irq module1", 1'h1, array_irq);
    wr(cac_pkg::CTRL_ADDR, 8'h40);
    rd_chk("flags cleared", cac_pkg::CTRL_ADDR, 8'h40);
    chk_bit("irq cleared", 1'h0, array_irq);
    // toggle with hit and mask, compare at 8
    wr(cac_pkg::MODE2_ADDR, 8'h4D);
    wr(cac_pkg::CMPL2_ADDR, 8'h08);
    rd_chk("low clears comparator_enable", cac_pkg::MODE2_ADDR, 8'h0D);
    wr(cac_pkg::CMPH2_ADDR, 8'h00);
    rd_chk("high sets comparator_enable", cac_pkg::MODE2_ADDR, 8'h4D);
    ticks(3, 1'h1);
    chk_bit("toggled pin", 1'h1, module2_output_pin);
    rd_chk("hit flag", cac_pkg::CTRL_ADDR, 8'h44);
    chk_bit("irq module2", 1'h1, array_irq);
    wr(cac_pkg::CTRL_ADDR, 8'h40);
    // capture edges, counter held still
    wr(cac_pkg::MODE2_ADDR, 8'h20);
    wr(cac_pkg::CMPL2_ADDR, 8'h00);
    cap(1'h1, 1'h1, 1'h0);
    rd_chk("captured low", cac_pkg::CMPL2_ADDR, 8'h08);
    cap(1'h0, 1'h0, 1'h0);
    wr(cac_pkg::MODE2_ADDR, 8'h11);
    cap(1'h1, 1'h0, 1'h0);
    cap(1'h0, 1'h1, 1'h1);
    // 8-bit pwm: low at match 0x0C, high at low byte zero
    wr(cac_pkg::CMPL2_ADDR, 8'h0C);
    wr(cac_pkg::CMPH2_ADDR, 8'h00);
    wr(cac_pkg::MODE2_ADDR, 8'h4A);
    ticks(6, 1'h1);
    chk_bit("pwm low after match", 1'h0, module2_output_pin);
    wr(cac_pkg::CTRL_ADDR, 8'h40);
    ticks(244, 1'h1);
    chk_bit("pwm up edge", 1'h1, module2_output_pin);
    rd_chk("up edge flag", cac_pkg::CTRL_ADDR, 8'h44);
    // 16-bit pwm through the wrap; 8-bit would hold low here
    wr(cac_pkg::CMPL2_ADDR, 8'h00);
    wr(cac_pkg::CMPH2_ADDR, 8'h80);
    wr(cac_pkg::MODE2_ADDR, 8'hCA);
    wr(cac_pkg::CTRL_ADDR, 8'h40);
    overflow_irq_enable = 1'h1;
    n = 32'h10002 - int'(exp_cnt);
    count_tick = 1'h1;
    repeat (n) @(negedge ref_clk);
    count_tick = 1'h0;
    exp_cnt = 16'h0002;
    ticks(0, 1'h0);
    chk_bit("wide pwm pin", 1'h1, module2_output_pin);
    rd_chk("overflow", cac_pkg::CTRL_ADDR, 8'hC4);
    chk_bit("irq overflow", 1'h1, array_irq);
    overflow_irq_enable = 1'h0;
    repeat (3) @(negedge ref_clk);
    chk_bit("irq ovf off", 1'h0, array_irq);
    rd_chk("overflow kept", cac_pkg::CTRL_ADDR, 8'hC4);
    // frequency output: every low-byte match flips the pin
    wr(cac_pkg::CMPL2_ADDR, 8'h05);
    wr(cac_pkg::CMPH2_ADDR, 8'h00);
    wr(cac_pkg::MODE2_ADDR, 8'h46);
    ticks(3, 1'h1);
    chk_bit("freq first hit", 1'h0, module2_output_pin);
    // pwm or toggle would leave the pin low at 0x105
    ticks(256, 1'h1);
    chk_bit("freq second hit", 1'h1, module2_output_pin);
    conclude();
  end
endmodule // cac_top_tb

//--- cac_unit.sv
// module 2 capture/compare unit: pin capture, match, toggle, pwm, freq out
// assumes step marks a fresh counter value, input pin is asynchronous
`timescale 1ns/1ps
module cac_unit (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic in_pin,
  cac_cc_if.unit    u
);
  logic [2:0] sy_q, sy_d;
  logic       pin_q, pin_d, cap_q, cap_d, hit_q, hit_d;
  logic       m16, m8, up16, up8, m, up, rise, fall;
  cac_pkg::cac_omode_t om;

  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    // stage 0 is read only by stage 1
    sy_d = {sy_q[1:0], in_pin};
    rise = sy_q[1] & ~sy_q[2];
    fall = ~sy_q[1] & sy_q[2];
    m16  = u.step & u.mode[cac_pkg::COMPARATOR_ENABLE_BIT] & (u.count == u.cmp); // [RULE9]
    m8   = u.step & u.mode[cac_pkg::COMPARATOR_ENABLE_BIT]
         & (u.count[7:0] == u.cmp[7:0]);
    up16 = u.step & (u.count == cac_pkg::CNT_ZERO);
    up8  = u.step & (u.count[7:0] == cac_pkg::LOW_ZERO);
    if (u.mode[cac_pkg::PWM_BIT] && u.mode[cac_pkg::FLIP_BIT])
      om = cac_pkg::OM_FREQ; // [RULE14]
    else if (u.mode[cac_pkg::PWM_BIT])
      om = u.mode[cac_pkg::WIDE_BIT] ? cac_pkg::OM_WIDE_PULSE_MODE
                                     : cac_pkg::OM_PWM8; // [RULE8]
    else if (u.mode[cac_pkg::FLIP_BIT])
      om = cac_pkg::OM_TOG;
    else
      om = cac_pkg::OM_IDLE;
    pin_d = pin_q;
    m     = m16;
    up    = 1'b0;
    unique case (om)
      cac_pkg::OM_IDLE:  pin_d = pin_q;
      cac_pkg::OM_TOG:   pin_d = pin_q ^ m16; // [RULE13]
      cac_pkg::OM_FREQ:
      begin
        m     = m8;
        pin_d = pin_q ^ m8;
      end
      // match priority: a compare of zero gives a flat low output
      cac_pkg::OM_PWM8:
      begin
        m  = m8;
        up = up8;
        if (m8)
          pin_d = 1'b0;
        else if (up8)
          pin_d = 1'b1; // [RULE15]
      end
      cac_pkg::OM_WIDE_PULSE_MODE:
      begin
        up = up16;
        if (m16)
          pin_d = 1'b0;
        else if (up16)
          pin_d = 1'b1; // [RULE15]
      end
    endcase
    hit_d = u.mode[cac_pkg::HIT_BIT] & (m | up); // [RULE12] [RULE18]
    cap_d = (rise & u.mode[cac_pkg::RISE_BIT])   // [RULE10]
          | (fall & u.mode[cac_pkg::FALL_BIT]);  // [RULE11]
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      sy_q  <= 3'h0;
      pin_q <= 1'b0;
      cap_q <= 1'b0;
      hit_q <= 1'b0;
    end
    else
    begin
      sy_q  <= sy_d;
      pin_q <= pin_d;
      cap_q <= cap_d;
      hit_q <= hit_d;
    end
  end

  assign u.pin    = pin_q;
  assign u.cap_ev = cap_q;
  assign u.hit_ev = hit_q;
endmodule // cac_unit
